// ---- rtl/spfc_pin_control.sv ----
// Top of the two auxiliary pin function controller
// Overview of operation
// - Mux pin low on emitters four to six
// - Mux pin undriven when no mux slot
// - Code 0000: second pin off, internal timing
// - Code 0001: mux, external clock times sample and exposure starts
// - Code 0010: sample trigger in, mux second
// - Code 0011: sample trigger, external exposure clock
// - Code 0100: drive sample timing, mux second
// - Code 0101: drive sample timing, external clock
// - Code 0110: exposure trigger input, mux second
// - Code 0111: drive exposure timing, mux second
// - Code 1000: drive exposure timing, external clock
// - Code 1001: fall aborts, clock rise restarts
`timescale 1ns/1ps
`default_nettype none
`include "spfc_consts.svh"
module spfc_pin_control
#(
    parameter int OSC_DIV = `SPFC_OSC_DIV,
    parameter int SAMPLE_TICKS = `SPFC_SAMPLE_TICKS,
    parameter int EXPO_TICKS = `SPFC_EXPO_TICKS
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic firstAuxPinIn,
    output logic firstAuxPinOut,
    output logic firstAuxPinOe,
    input wire logic secondAuxPinIn,
    output logic secondAuxPinOut,
    output logic secondAuxPinOe,
    output logic exposureActive,
    output logic sampleStart
);
    generate
        if (OSC_DIV < 2 || OSC_DIV > 16777216 || SAMPLE_TICKS < 8
            || EXPO_TICKS < 1 || EXPO_TICKS > 255 || SAMPLE_TICKS > 65535)
        begin : g_bad_params
            $error("spfc_pin_control: unsupported timing parameters");
        end
    endgenerate

    localparam int NSLOT = `SPFC_SLOTS_PER_SAMPLE;
    localparam logic [23:0] DIV_LAST = 24'(OSC_DIV - 1);
    localparam logic [15:0] SMP_LAST = 16'(SAMPLE_TICKS - 1);
    localparam logic [7:0] EXP_LAST = 8'(EXPO_TICKS - 1);

    // Slot code: 0 empty, 1..3 emitters 1-3, 4..6 emitters 4-6 through mux
    // (states A, B, C), 7 ambient
    function automatic logic slotUsesMux(input logic [3:0] code);
        slotUsesMux = (code >= 4'h4) && (code <= 4'h6);
    endfunction

    function automatic logic slotUsed(input logic [3:0] code);
        slotUsed = (code != 4'h0);
    endfunction

    typedef struct packed {
        logic [23:0] divCnt;
        logic oscTick;
        logic [15:0] smpCnt;
        spfc_pkg::spfc_seq_t seq;
        logic [2:0] slot;
        logic [7:0] expCnt;
        logic muxLow;
        logic expOut;
        logic smpOut;
        logic startPulse;
        logic armed;
        logic [15:0] sampleCount;
    } spfc_state_t;

    spfc_state_t st;
    spfc_state_t next_st;

    logic [3:0] selCode;
    logic swSyncPulse;
    logic [23:0] slotTable;
    logic [31:0] statusWord;
    logic p1Level, p1Rise, p1Fall;
    logic p2Level, p2Rise, p2Fall;
    spfc_pkg::spfc_sel_t mode;
    logic anyMux;
    logic [NSLOT-1:0] muxSlot;
    logic [NSLOT-1:0] usedSlot;
    logic extClk;
    logic slaveSample;
    logic slaveExpose;
    logic masterSample;
    logic masterExpose;
    logic muxOnFirst;
    logic tick;
    logic sampleTrig;
    logic exposeTrig;
    logic abortSeq;
    logic lastSlot;

    spfc_apb_regs u_regs
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .statusWord(statusWord),
        .selCode(selCode),
        .swSyncPulse(swSyncPulse),
        .slotTable(slotTable)
    );

    spfc_sync_edge u_sync1
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pinIn(firstAuxPinIn),
        .level(p1Level),
        .rise(p1Rise),
        .fall(p1Fall)
    );

    spfc_sync_edge u_sync2
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pinIn(secondAuxPinIn),
        .level(p2Level),
        .rise(p2Rise),
        .fall(p2Fall)
    );

    genvar g;
    generate
        for (g = 0; g < NSLOT; g++)
        begin : g_slot
            assign muxSlot[g] = slotUsesMux(slotTable[g*4 +: 4]);
            assign usedSlot[g] = slotUsed(slotTable[g*4 +: 4]);
        end
    endgenerate
    assign anyMux = |muxSlot;

    assign mode = (selCode > 4'h9) ? spfc_pkg::SEL_INTERNAL
        : spfc_pkg::spfc_sel_t'(selCode);

    always_comb
    begin
        extClk = 1'b0;
        slaveSample = 1'b0;
        slaveExpose = 1'b0;
        masterSample = 1'b0;
        masterExpose = 1'b0;
        muxOnFirst = 1'b0;
        case (mode)
            spfc_pkg::SEL_INTERNAL: muxOnFirst = 1'b1;
            spfc_pkg::SEL_MUX1_EXTCLK:
            begin
                muxOnFirst = 1'b1;
                extClk = 1'b1;
            end
            spfc_pkg::SEL_SLVSMP_MUX2: slaveSample = 1'b1;
            spfc_pkg::SEL_SLVSMP_EXTCLK:
            begin
                slaveSample = 1'b1;
                extClk = 1'b1;
            end
            spfc_pkg::SEL_MSTSMP_MUX2: masterSample = 1'b1;
            spfc_pkg::SEL_MSTSMP_EXTCLK:
            begin
                masterSample = 1'b1;
                extClk = 1'b1;
            end
            spfc_pkg::SEL_SLVEXP_MUX2: slaveExpose = 1'b1;
            spfc_pkg::SEL_MSTEXP_MUX2: masterExpose = 1'b1;
            spfc_pkg::SEL_MSTEXP_EXTCLK:
            begin
                masterExpose = 1'b1;
                extClk = 1'b1;
            end
            spfc_pkg::SEL_RESTART_SYNC: extClk = 1'b1;
            default: muxOnFirst = 1'b1;
        endcase
    end

    assign tick = extClk ? p2Rise : st.oscTick;
    // Slave modes ignore the local sample counter entirely
    assign sampleTrig = (slaveSample || slaveExpose) ? p1Rise
        : (tick && (!st.armed || st.smpCnt == SMP_LAST));
    assign exposeTrig = slaveExpose ? p1Rise : tick;
    assign abortSeq = ((mode == spfc_pkg::SEL_RESTART_SYNC) && p1Fall)
        || swSyncPulse;
    assign lastSlot = (st.slot == 3'(NSLOT - 1));

    always_comb
    begin
        next_st = st;
        next_st.startPulse = 1'b0;
        next_st.oscTick = 1'b0;
        if (st.divCnt == DIV_LAST)
        begin
            next_st.divCnt = 24'h00_0000;
            next_st.oscTick = 1'b1;
        end
        else
            next_st.divCnt = st.divCnt + 24'h00_0001;
        if (tick)
            next_st.smpCnt = (st.smpCnt == SMP_LAST) ? 16'h0000
                : st.smpCnt + 16'h0001;
        // A restart begins a fresh sample on the next timing tick
        if (!st.armed && tick)
        begin
            next_st.armed = 1'b1;
            next_st.smpCnt = 16'h0000;
        end
        case (st.seq)
            spfc_pkg::SEQ_IDLE:
            begin
                if (sampleTrig)
                begin
                    next_st.seq = spfc_pkg::SEQ_GAP;
                    next_st.slot = 3'h0;
                    next_st.startPulse = 1'b1;
                    next_st.sampleCount = st.sampleCount + 16'h0001;
                    // Slave exposure trigger also opens first exposure when slot 0 is used
                    if (slaveExpose && usedSlot[0])
                    begin
                        next_st.seq = spfc_pkg::SEQ_EXPOSE;
                        next_st.expCnt = 8'h00;
                        next_st.muxLow = muxSlot[0];
                    end
                end
            end
            spfc_pkg::SEQ_GAP:
            begin
                if (exposeTrig)
                begin
                    if (usedSlot[st.slot])
                    begin
                        next_st.seq = spfc_pkg::SEQ_EXPOSE;
                        next_st.expCnt = 8'h00;
                        next_st.muxLow = muxSlot[st.slot];
                    end
                    else
                        next_st.seq = spfc_pkg::SEQ_IDLE;
                end
            end
            spfc_pkg::SEQ_EXPOSE:
            begin
                if (st.expCnt == EXP_LAST)
                begin
                    next_st.muxLow = 1'b0;
                    next_st.slot = st.slot + 3'h1;
                    next_st.seq = lastSlot ? spfc_pkg::SEQ_IDLE
                        : spfc_pkg::SEQ_GAP;
                end
                else if (!slaveExpose || tick)
                    next_st.expCnt = st.expCnt + 8'h01;
            end
            default: next_st.seq = spfc_pkg::SEQ_IDLE;
        endcase
        if (abortSeq)
        begin
            next_st.seq = spfc_pkg::SEQ_IDLE;
            next_st.muxLow = 1'b0;
            next_st.armed = 1'b0;
            // Abort beats a start in the same cycle
            next_st.startPulse = 1'b0;
            next_st.sampleCount = st.sampleCount;
        end
        next_st.expOut = (next_st.seq == spfc_pkg::SEQ_EXPOSE);
        next_st.smpOut = (next_st.seq != spfc_pkg::SEQ_IDLE);
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
            st.seq <= spfc_pkg::SEQ_IDLE;
            st.armed <= 1'b1;
        end
        else
            st <= next_st;
    end

    always_comb
    begin
        firstAuxPinOut = 1'b1;
        firstAuxPinOe = 1'b0;
        secondAuxPinOut = 1'b1;
        secondAuxPinOe = 1'b0;
        if (muxOnFirst)
        begin
            firstAuxPinOut = ~st.muxLow;
            firstAuxPinOe = anyMux;
        end
        else if (!extClk)
        begin
            secondAuxPinOut = ~st.muxLow;
            secondAuxPinOe = anyMux;
        end
        if (masterSample)
        begin
            firstAuxPinOut = st.smpOut;
            firstAuxPinOe = 1'b1;
        end
        if (masterExpose)
        begin
            firstAuxPinOut = st.expOut;
            firstAuxPinOe = 1'b1;
        end
    end

    assign statusWord = {st.sampleCount, 3'h0, p2Level, p1Level, anyMux,
        st.armed, st.seq, st.slot, mode[3:0]};
    assign exposureActive = st.expOut;
    assign sampleStart = st.startPulse;
endmodule // spfc_pin_control
`default_nettype wire

// ---- rtl/spfc_consts.svh ----
// Offsets, field positions, reset values and timing counts for pin control
`ifndef SPFC_CONSTS_SVH
`define SPFC_CONSTS_SVH
`define SPFC_OFF_CTRL 12'h000
`define SPFC_OFF_SEQ 12'h004
`define SPFC_OFF_STAT 12'h008
`define SPFC_OFF_ID 12'h00C
`define SPFC_CTRL_SEL_LSB 0
`define SPFC_CTRL_SEL_MSB 3
`define SPFC_CTRL_SWSYNC_BIT 4
`define SPFC_CTRL_RESET 32'h0000_0000
`define SPFC_SEQ_RESET 32'h0000_0000
// Identification word; the value is arbitrary
`define SPFC_ID_VALUE 32'h0000_5A01
`define SPFC_CLK_MHZ 125
`define SPFC_OSC_HZ 32768
`define SPFC_OSC_DIV ((`SPFC_CLK_MHZ * 1000000) / (`SPFC_OSC_HZ * 2))
`define SPFC_EXPO_TICKS 4
`define SPFC_SLOTS_PER_SAMPLE 6
`define SPFC_SAMPLE_TICKS 32
`endif

// ---- rtl/spfc_pkg.sv ----
// Types shared by the pin function control block
package spfc_pkg;
    typedef enum logic [3:0] {
        SEL_INTERNAL,
        SEL_MUX1_EXTCLK,
        SEL_SLVSMP_MUX2,
        SEL_SLVSMP_EXTCLK,
        SEL_MSTSMP_MUX2,
        SEL_MSTSMP_EXTCLK,
        SEL_SLVEXP_MUX2,
        SEL_MSTEXP_MUX2,
        SEL_MSTEXP_EXTCLK,
        SEL_RESTART_SYNC
    } spfc_sel_t;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_EXPOSE,
        SEQ_GAP
    } spfc_seq_t;
endpackage

// ---- rtl/spfc_sync_edge.sv ----
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module spfc_sync_edge
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } spfc_se_t;
    spfc_se_t st;
    spfc_se_t next_st;
    always_comb
    begin
        next_st = st;
        next_st.meta = pinIn;
        next_st.sync = st.meta;
        next_st.last = st.sync;
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            // Pins idle high on their pull-ups: no false edge after reset
            st <= '1;
        else
            st <= next_st;
    end
    assign level = st.sync;
    assign rise = st.sync & ~st.last;
    assign fall = ~st.sync & st.last;
endmodule // spfc_sync_edge
`default_nettype wire

// ---- rtl/spfc_apb_regs.sv ----
// APB register file for selector, slot table and status
`timescale 1ns/1ps
`default_nettype none
`include "spfc_consts.svh"
module spfc_apb_regs
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] statusWord,
    output logic [3:0] selCode,
    output logic swSyncPulse,
    output logic [23:0] slotTable
);
    typedef struct packed {
        logic [3:0] sel;
        logic swSync;
        logic [23:0] slots;
        logic [31:0] rdata;
        logic err;
    } spfc_regs_t;
    spfc_regs_t st;
    spfc_regs_t next_st;
    logic access;
    logic known;
    assign access = psel & penable;
    assign known = (paddr == `SPFC_OFF_CTRL) || (paddr == `SPFC_OFF_SEQ)
        || (paddr == `SPFC_OFF_STAT) || (paddr == `SPFC_OFF_ID);
    always_comb
    begin
        next_st = st;
        next_st.swSync = 1'b0;
        next_st.err = 1'b0;
        if (psel && !penable)
        begin
            next_st.err = ~known;
            case (paddr)
                `SPFC_OFF_CTRL: next_st.rdata = {28'h000_0000, st.sel};
                `SPFC_OFF_SEQ: next_st.rdata = {8'h00, st.slots};
                `SPFC_OFF_STAT: next_st.rdata = statusWord;
                `SPFC_OFF_ID: next_st.rdata = `SPFC_ID_VALUE;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (access && pwrite && known)
        begin
            if (paddr == `SPFC_OFF_CTRL && pstrb[0])
            begin
                next_st.sel = pwdata[`SPFC_CTRL_SEL_MSB:`SPFC_CTRL_SEL_LSB];
                next_st.swSync = pwdata[`SPFC_CTRL_SWSYNC_BIT];
            end
            if (paddr == `SPFC_OFF_SEQ)
            begin
                if (pstrb[0])
                    next_st.slots[7:0] = pwdata[7:0];
                if (pstrb[1])
                    next_st.slots[15:8] = pwdata[15:8];
                if (pstrb[2])
                    next_st.slots[23:16] = pwdata[23:16];
            end
        end
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st.sel <= 4'h0;
            st.swSync <= 1'b0;
            st.slots <= 24'h00_0000;
            st.rdata <= 32'h0000_0000;
            st.err <= 1'b0;
        end
        else
            st <= next_st;
    end
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = access & st.err;
    assign selCode = st.sel;
    assign swSyncPulse = st.swSync;
    assign slotTable = st.slots;
endmodule // spfc_apb_regs
`default_nettype wire

// ---- tb/spfc_pin_control_checker.sv ----
// Port-level assertions for the auxiliary pin function controller
`timescale 1ns/1ps
`default_nettype none
`include "spfc_consts.svh"
module spfc_pin_control_checker
#(
    parameter int OSC_DIV = 4,
    parameter int SAMPLE_TICKS = 32,
    parameter int EXPO_TICKS = 4
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic firstAuxPinIn,
    input wire logic firstAuxPinOut,
    input wire logic firstAuxPinOe,
    input wire logic secondAuxPinOe,
    input wire logic exposureActive,
    input wire logic sampleStart
);
    logic [3:0] sel;
    logic anyMux;
    logic [2:0] age;
    logic wrEn;
    logic ok;
    // Shadow assumes whole-word writes; partial strobes are not tracked
    function automatic logic hasMux(input logic [31:0] w);
        logic r;
        r = 1'b0;
        for (int k = 0; k < 6; k++)
            r = r | (w[4*k +: 4] inside {4'h4, 4'h5, 4'h6});
        return r;
    endfunction
    assign wrEn = psel && penable && pwrite && pready;
    // Outputs may lag a write by a few cycles, so wait before judging
    assign ok = age > 3'h3;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sel <= 4'h0;
            anyMux <= 1'b0;
            age <= 3'h0;
        end
        else if (wrEn && (paddr == `SPFC_OFF_CTRL || paddr == `SPFC_OFF_SEQ))
        begin
            age <= 3'h0;
            if (paddr == `SPFC_OFF_CTRL)
                sel <= pwdata[3:0];
            else
                anyMux <= hasMux(pwdata);
        end
        else if (age != 3'h7)
            age <= age + 3'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    AST_MUX1_OE:
    assert property (ok && sel < 4'h2 |-> firstAuxPinOe == anyMux)
        else $error("first pin mux enable wrong");
    AST_MUX1_LEVEL:
    assert property (ok && sel < 4'h2 && firstAuxPinOe && !exposureActive
        |-> firstAuxPinOut) else $error("first pin mux level low");
    AST_RESERVED:
    assert property (ok && sel > 4'h9 |-> !secondAuxPinOe
        && firstAuxPinOe == anyMux) else $error("reserved code pins");
    AST_SECOND_OFF:
    assert property (ok && sel == 4'h0 |-> !secondAuxPinOe)
        else $error("second pin driven in internal mode");
    AST_EXT_CLOCK_IN:
    assert property (ok && sel inside {4'h1, 4'h3, 4'h5, 4'h8, 4'h9}
        |-> !secondAuxPinOe) else $error("clock pin driven");
    AST_MASTER_DRIVE:
    assert property (ok && sel inside {4'h4, 4'h5, 4'h7, 4'h8}
        |-> firstAuxPinOe) else $error("master pin not driven");
    AST_SLAVE_INPUT:
    assert property (ok && sel inside {4'h2, 4'h3, 4'h6, 4'h9}
        |-> !firstAuxPinOe) else $error("slave pin driven");
    AST_START_PULSE:
    assert property (sampleStart |=> !sampleStart)
        else $error("sample start longer than a cycle");
    AST_SLAVE_START:
    assert property (ok && sel == 4'h2 && $rose(firstAuxPinIn)
        |-> ##[1:6] sampleStart) else $error("trigger missed");
    AST_EXPO_START:
    assert property (ok && sel == 4'h6 && $rose(firstAuxPinIn)
        |-> ##[1:6] $rose(exposureActive)) else $error("exposure missed");
endmodule // spfc_pin_control_checker
`default_nettype wire

// ---- tb/spfc_far_side.sv ----
// Trigger and reference clock source wired to the auxiliary pins
`timescale 1ns/1ps
`default_nettype none
module spfc_far_side
(
    input wire logic pin1Oe,
    input wire logic pin1Out,
    input wire logic pin2Oe,
    input wire logic pin2Out,
    output wire logic pin1Level,
    output wire logic pin2Level
);
    logic drive1 = 1'b0;
    logic lvl1 = 1'b1;
    logic clkRun = 1'b0;
    logic clkLvl = 1'b0;
    assign pin1Level = pin1Oe ? pin1Out : (drive1 ? lvl1 : 1'b1);
    assign pin2Level = pin2Oe ? pin2Out : (clkRun ? clkLvl : 1'b1);
    // reference clock, running only while clkRun is set, offset from the system clock
    initial
    begin
        #13;
        forever #32 clkLvl = clkRun ? ~clkLvl : 1'b0;
    end
    task automatic pulse();
        drive1 = 1'b1;
        lvl1 = 1'b0;
        #100;
        lvl1 = 1'b1;
        #100;
        drive1 = 1'b0;
    endtask
    task automatic hold_low();
        drive1 = 1'b1;
        lvl1 = 1'b0;
    endtask
endmodule // spfc_far_side
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the auxiliary pin function controller
`timescale 1ns/1ps
`default_nettype none
`include "spfc_consts.svh"
module tb;
    localparam int SMP = 32;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] seqWord;
    logic [3:0] pstrb = 4'hF;
    logic apbErr;
    logic [7:0] rnd = 8'h2C;
    logic pready, pslverr, pin1Out, pin1Oe, pin2Out, pin2Oe;
    logic exposureActive, sampleStart;
    logic expoPrev = 1'b0;
    wire logic pin1Level;
    wire logic pin2Level;
    int fail_count = 0;
    int samples_checked = 0;
    int starts = 0;
    int expos = 0;
    int cyc;
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    // one timing set for device and checker
    spfc_pin_control #(.OSC_DIV(4), .SAMPLE_TICKS(SMP), .EXPO_TICKS(4))
    i_spfc_pin_control (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .firstAuxPinIn(pin1Level),
        .firstAuxPinOut(pin1Out), .firstAuxPinOe(pin1Oe),
        .secondAuxPinIn(pin2Level), .secondAuxPinOut(pin2Out),
        .secondAuxPinOe(pin2Oe), .exposureActive(exposureActive),
        .sampleStart(sampleStart));
    spfc_far_side i_spfc_far_side (.pin1Oe(pin1Oe), .pin1Out(pin1Out),
        .pin2Oe(pin2Oe), .pin2Out(pin2Out), .pin1Level(pin1Level),
        .pin2Level(pin2Level));
    always @(posedge clk_sys)
    begin
        expoPrev <= exposureActive;
        if (sampleStart === 1'b1)
            starts++;
        if (exposureActive === 1'b1 && expoPrev === 1'b0)
            expos++;
    end
    function automatic logic [7:0] nextRand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Expected pin enables per selector code and mux use
    function automatic logic [1:0] expOe(input int s, input logic mx);
        logic o1;
        logic o2;
        o1 = (s < 2 || s > 9) ? mx : (s inside {4, 5, 7, 8});
        o2 = (s inside {2, 4, 6, 7}) ? mx : 1'b0;
        return {o1, o2};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic r;
        apb(1'b1, a, d, q, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
            input logic e);
        logic [31:0] q;
        logic r;
        apb(1'b0, a, 32'h0000_0000, q, r);
        chk(q, d);
        chk(r, e);
    endtask
    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end
    initial
    begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        chk({pin1Oe, pin2Oe}, 2'h0);
        rd(`SPFC_OFF_CTRL, `SPFC_CTRL_RESET, 1'b0);
        rd(`SPFC_OFF_SEQ, `SPFC_SEQ_RESET, 1'b0);
        wr(`SPFC_OFF_ID, 32'hFFFF_FFFF);
        rd(`SPFC_OFF_ID, `SPFC_ID_VALUE, 1'b0);
        rd(12'h010, 32'h0000_0000, 1'b1);
        // Slot table byte lanes follow the strobes
        pstrb <= 4'h1;
        wr(`SPFC_OFF_SEQ, 32'h0000_0444);
        pstrb <= 4'hF;
        rd(`SPFC_OFF_SEQ, 32'h0000_0044, 1'b0);
        // Every selector code, without and with a mux slot
        for (int m = 0; m < 32; m++)
        begin
            if (m % 16 == 0)
                wr(`SPFC_OFF_SEQ, (m == 16) ? 32'h0000_0004 : 32'h0000_0000);
            wr(`SPFC_OFF_CTRL, m % 16);
            repeat (4) @(posedge clk_sys);
            rd(`SPFC_OFF_CTRL, m % 16, 1'b0);
            chk({pin1Oe, pin2Oe}, expOe(m % 16, m >= 16));
            // status read after the control readback
            apb(1'b0, `SPFC_OFF_STAT, 32'h0000_0000, seqWord, apbErr);
            chk(seqWord[3:0], (m % 16 > 9) ? 0 : m % 16);
            chk(seqWord[10], m >= 16);
        end
        seqWord = 32'h0000_0000;
        for (int i = 0; i < 6; i++)
        begin
            rnd = nextRand(rnd);
            seqWord[4*i +: 4] = 4'h4 + rnd[3:0] % 4'h3;
        end
        // one slot table for every role
        wr(`SPFC_OFF_SEQ, seqWord);
        // Internal, master sample and master exposure codes
        for (int m = 0; m < 3; m++)
        begin
            wr(`SPFC_OFF_CTRL, (m == 2) ? 32'h0000_0007 : m * 4);
            repeat (4) @(posedge clk_sys);
            expos = 0;
            repeat (800)
            begin
                @(posedge clk_sys);
                chk(m ? pin2Out : pin1Out, !exposureActive);
                if (m == 1 && sampleStart === 1'b1)
                    chk(pin1Out, 1'b1);
                if (m == 2)
                    chk(pin1Out, exposureActive);
            end
            chk(expos > 0, 1'b1);
        end
        // Slave sample trigger then slave exposure trigger
        // slave role set before any trigger arrives
        for (int m = 0; m < 2; m++)
        begin
            wr(`SPFC_OFF_CTRL, m ? 32'h0000_0006 : 32'h0000_0002);
            repeat (400) @(posedge clk_sys);
            starts = 0;
            expos = 0;
            repeat (m ? 6 : 3)
            begin
                i_spfc_far_side.pulse();
                repeat (m ? 150 : 400) @(posedge clk_sys);
            end
            chk(m ? expos : starts, m ? 6 : 3);
        end
        // Fall on the first pin restarts on a reference clock rise
        i_spfc_far_side.clkRun = 1'b1;
        wr(`SPFC_OFF_CTRL, 32'h0000_0009);
        repeat (600) @(posedge clk_sys);
        starts = 0;
        cyc = 0;
        i_spfc_far_side.hold_low();
        while (starts == 0 && cyc < 2000)
        begin
            @(posedge clk_sys);
            cyc++;
        end
        // Due within two reference periods plus sync latency
        chk(cyc >= 1 && cyc <= 2 * 8 + 2, 1'b1);
        // Software restart on internal timing
        starts = 0;
        wr(`SPFC_OFF_CTRL, 32'h0000_0010);
        cyc = 0;
        while (starts == 0 && cyc < 2000)
        begin
            @(posedge clk_sys);
            cyc++;
        end
        chk(cyc <= 8, 1'b1);
        summarize();
    end
endmodule // tb
bind spfc_pin_control spfc_pin_control_checker #(.OSC_DIV(OSC_DIV),
    .SAMPLE_TICKS(SAMPLE_TICKS), .EXPO_TICKS(EXPO_TICKS))
i_spfc_pin_control_checker (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .firstAuxPinIn(firstAuxPinIn),
    .firstAuxPinOut(firstAuxPinOut), .firstAuxPinOe(firstAuxPinOe),
    .secondAuxPinOe(secondAuxPinOe), .exposureActive(exposureActive),
    .sampleStart(sampleStart));
`default_nettype wire
